/* File: hdl/anvm_host.sv */
`timescale 1ns/1ps
// Summary of operation
// - No access before 2 ms startup.
// - Hold chip select and commit high meanwhile.
// - Brownout restarts the full startup wait.
// - Commit stays high through every read.
// - Reads spaced at least 35 ns apart.
// - Address valid no later than select falls.
// - Write only while select and commit low.
// - Writes spaced at least 35 ns apart.
module anvm_host #(
   parameter int STARTUP_CLKS = anvm_pkg::STARTUP_CLKS
)(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_brownout,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [anvm_pkg::ADDR_W-1:0] i_addr,
   input wire logic [1:0] i_be,
   input wire logic [anvm_pkg::DATA_W-1:0] i_wdata,
   output logic o_ready,
   output logic o_done,
   output logic [anvm_pkg::DATA_W-1:0] o_rdata,
   output logic [anvm_pkg::ADDR_W-1:0] o_mem_addr,
   output logic o_cs_n,
   output logic o_commit_n,
   output logic o_out_on_n,
   output logic o_lo_lane_n,
   output logic o_hi_lane_n,
   input wire logic [7:0] i_lo_io,
   input wire logic [7:0] i_hi_io,
   output logic [7:0] o_lo_io,
   output logic [7:0] o_hi_io,
   output logic o_lo_io_oe,
   output logic o_hi_io_oe
);
   typedef struct packed
   {
      anvm_pkg::anvm_state_t state;
      logic [anvm_pkg::TMR_W-1:0] tmr;
      logic ready;
      logic done;
      logic [anvm_pkg::DATA_W-1:0] rdata;
      logic [anvm_pkg::ADDR_W-1:0] addr;
      logic cs_n;
      logic commit_n;
      logic out_on_n;
      logic lo_n;
      logic hi_n;
      logic [anvm_pkg::DATA_W-1:0] wdata;
      logic oe;
      logic brn_s1;
      logic brn_s2;
      logic [7:0] lo_s1;
      logic [7:0] lo_s2;
      logic [7:0] hi_s1;
      logic [7:0] hi_s2;
   } anvm_host_t;
   anvm_host_t st_r;
   anvm_host_t st_nxt;
   logic stup_ready;

   // The brownout flag is a pin, so it reaches the counter only after two flops.
   anvm_startup #(
      .STARTUP_CLKS(STARTUP_CLKS)
   ) u_startup (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_restart(st_r.brn_s2),
      .o_ready(stup_ready)
   );

   // Sequencer: every phase lasts a whole number of cycles rounded in the safe direction.
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.brn_s1 = i_brownout;
      st_nxt.brn_s2 = st_r.brn_s1;
      st_nxt.lo_s1 = i_lo_io;
      st_nxt.lo_s2 = st_r.lo_s1;
      st_nxt.hi_s1 = i_hi_io;
      st_nxt.hi_s2 = st_r.hi_s1;
      st_nxt.done = 1'b0;
      if (st_r.tmr != '0)
         st_nxt.tmr = st_r.tmr - 16'h0001;
      case (st_r.state)
         anvm_pkg::ANVM_WAIT:
         begin
            // Select and commit stay high until the wait ends; brownout sends us back here.
            st_nxt.cs_n = 1'b1;
            st_nxt.commit_n = 1'b1;
            st_nxt.oe = 1'b0;
            st_nxt.ready = 1'b0;
            if (stup_ready && !st_r.brn_s2)
            begin
               st_nxt.state = anvm_pkg::ANVM_IDLE;
               st_nxt.ready = 1'b1;
            end
         end
         anvm_pkg::ANVM_IDLE:
         begin
            if (st_r.brn_s2)
            begin
               st_nxt.state = anvm_pkg::ANVM_WAIT;
               st_nxt.ready = 1'b0;
            end
            else if (i_req && st_r.tmr == '0)
            begin
               // Address, lanes and select change together so the address is valid at select fall.
               st_nxt.addr = i_addr;
               st_nxt.cs_n = 1'b0;
               st_nxt.lo_n = ~i_be[0];
               st_nxt.hi_n = ~i_be[1];
               st_nxt.wdata = i_wdata;
               st_nxt.ready = 1'b0;
               if (i_we)
               begin
                  st_nxt.state = anvm_pkg::ANVM_WR;
                  st_nxt.commit_n = 1'b0;
                  st_nxt.out_on_n = 1'b1;
                  st_nxt.oe = 1'b1;
                  st_nxt.tmr = 16'(anvm_pkg::WRP_CLKS);
               end
               else
               begin
                  st_nxt.state = anvm_pkg::ANVM_RD;
                  st_nxt.commit_n = 1'b1;
                  st_nxt.out_on_n = 1'b0;
                  // Two extra cycles cover the input synchroniser.
                  st_nxt.tmr = 16'(anvm_pkg::ACC_CLKS + 2);
               end
            end
         end
         anvm_pkg::ANVM_RD:
         begin
            if (st_r.tmr == '0)
            begin
               st_nxt.rdata = {st_r.hi_s2, st_r.lo_s2};
               st_nxt.cs_n = 1'b1;
               st_nxt.out_on_n = 1'b1;
               st_nxt.done = 1'b1;
               st_nxt.state = anvm_pkg::ANVM_REL;
               // Bus float time also covers the next cycle-time spacing.
               st_nxt.tmr = 16'(anvm_pkg::HIZ_CLKS + anvm_pkg::CYC_CLKS);
            end
         end
         anvm_pkg::ANVM_WR:
         begin
            if (st_r.tmr == '0)
            begin
               // Commit and select rise together ending the write; data is held one more cycle.
               st_nxt.commit_n = 1'b1;
               st_nxt.cs_n = 1'b1;
               st_nxt.done = 1'b1;
               st_nxt.state = anvm_pkg::ANVM_REL;
               st_nxt.tmr = 16'(anvm_pkg::REC_CLKS + anvm_pkg::CYC_CLKS);
            end
         end
         anvm_pkg::ANVM_REL:
         begin
            st_nxt.oe = 1'b0;
            if (st_r.tmr == '0)
            begin
               // A brownout that came and went during the access has restarted the wait, so go back to it.
               if (stup_ready && !st_r.brn_s2)
               begin
                  st_nxt.state = anvm_pkg::ANVM_IDLE;
                  st_nxt.ready = 1'b1;
               end
               else
                  st_nxt.state = anvm_pkg::ANVM_WAIT;
            end
         end
         default:
            st_nxt.state = anvm_pkg::ANVM_WAIT;
      endcase
   end

   // State register; strobes reset high so the memory sees no access.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         st_r <= '0;
         st_r.cs_n <= 1'b1;
         st_r.commit_n <= 1'b1;
         st_r.out_on_n <= 1'b1;
         st_r.lo_n <= 1'b1;
         st_r.hi_n <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   // All outputs come straight from the state register.
   assign o_ready = st_r.ready;
   assign o_done = st_r.done;
   assign o_rdata = st_r.rdata;
   assign o_mem_addr = st_r.addr;
   assign o_cs_n = st_r.cs_n;
   assign o_commit_n = st_r.commit_n;
   assign o_out_on_n = st_r.out_on_n;
   assign o_lo_lane_n = st_r.lo_n;
   assign o_hi_lane_n = st_r.hi_n;
   assign o_lo_io = st_r.wdata[7:0];
   assign o_hi_io = st_r.wdata[15:8];
   assign o_lo_io_oe = st_r.oe;
   assign o_hi_io_oe = st_r.oe;
endmodule : anvm_host

/* File: hdl/anvm_pkg.sv */
package anvm_pkg;
   // Array geometry.
   localparam int ADDR_W = 17;
   localparam int DATA_W = 16;
   localparam int WORDS = 131072;
   // Clock rate and documented times.
   localparam int CLK_PERIOD_PS = 40000;
   localparam int STARTUP_US = 2000;
   localparam int CYCLE_NS = 35;
   localparam int ACCESS_NS = 35;
   localparam int OE_ACCESS_NS = 15;
   localparam int HIZ_OE_NS = 10;
   localparam int HIZ_CS_NS = 15;
   localparam int WR_PULSE_NS = 15;
   localparam int WR_RECOVER_NS = 12;
   // Least times round up to whole cycles, never below one.
   localparam int CYC_CLKS = (CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ACC_CLKS = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WRP_CLKS = (WR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HIZ_CLKS = (HIZ_CS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int REC_CLKS = (WR_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STARTUP_CLKS = (STARTUP_US * 1000000) / CLK_PERIOD_PS + 1;
   localparam int TMR_W = 16;
   localparam int STUP_W = 17;
   // Controller states.
   typedef enum logic [2:0]
   {
      ANVM_WAIT = 3'b000,
      ANVM_IDLE = 3'b001,
      ANVM_RD = 3'b010,
      ANVM_WR = 3'b011,
      ANVM_REL = 3'b100
   } anvm_state_t;
endpackage : anvm_pkg

/* File: hdl/anvm_startup.sv */
`timescale 1ns/1ps
// Power-up hold-off: counts from reset or from a brownout report and raises ready once the wait is over.
module anvm_startup #(
   parameter int STARTUP_CLKS = anvm_pkg::STARTUP_CLKS
)(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_restart,
   output logic o_ready
);
   typedef struct packed
   {
      logic [anvm_pkg::STUP_W-1:0] cnt;
      logic ready;
   } anvm_stup_t;
   anvm_stup_t st_r;
   anvm_stup_t st_nxt;

   // Count up to the wait; a brownout starts the whole wait over.
   always_comb
   begin
      st_nxt = st_r;
      if (i_restart)
      begin
         st_nxt.cnt = '0;
         st_nxt.ready = 1'b0;
      end
      else if (st_r.cnt >= anvm_pkg::STUP_W'(STARTUP_CLKS - 1))
         st_nxt.ready = 1'b1;
      else
         st_nxt.cnt = st_r.cnt + 17'h00001;
   end

   // State register.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign o_ready = st_r.ready;
endmodule : anvm_startup

/* File: test/anvm_host_properties.sv */
`timescale 1ns/1ps
// Watches the memory strobes; the startup count here restarts on the raw brownout, two cycles ahead of the host's synchronised restart.
module anvm_chk #(
   parameter int STARTUP_CLKS = 20
)(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_brownout,
   input wire logic o_ready,
   input wire logic o_cs_n,
   input wire logic o_commit_n,
   input wire logic o_out_on_n,
   input wire logic [anvm_pkg::ADDR_W-1:0] o_mem_addr,
   input wire logic o_lo_io_oe,
   input wire logic o_hi_io_oe
);
   logic [31:0] up_r;
   // Cycles since reset or brownout, saturating at the wait.
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst) up_r <= '0;
      else if (i_brownout) up_r <= '0;
      else if (up_r < STARTUP_CLKS) up_r <= up_r + 1;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_boot; !o_cs_n |-> up_r >= STARTUP_CLKS; endproperty
   a_boot: assert property (p_boot) else $error("select during startup wait");
   property p_hold; !o_commit_n |-> up_r >= STARTUP_CLKS; endproperty
   a_hold: assert property (p_hold) else $error("commit during startup wait");
   property p_rd; !o_out_on_n |-> o_commit_n && !o_lo_io_oe && !o_hi_io_oe; endproperty
   a_rd: assert property (p_rd) else $error("read with commit or drive");
   property p_acc; $fell(o_cs_n) && !o_out_on_n |-> !o_cs_n [*3]; endproperty
   a_acc: assert property (p_acc) else $error("read select too short");
   property p_addr; !o_cs_n && !$past(o_cs_n) |-> $stable(o_mem_addr); endproperty
   a_addr: assert property (p_addr) else $error("address moved in access");
   property p_wr; !o_commit_n |-> !o_cs_n && o_lo_io_oe && o_hi_io_oe; endproperty
   a_wr: assert property (p_wr) else $error("write without select or data");
   property p_gap; $rose(o_cs_n) |=> o_cs_n [*3]; endproperty
   a_gap: assert property (p_gap) else $error("accesses too close");
   property p_idle; o_ready |-> o_cs_n && o_commit_n && o_out_on_n; endproperty
   a_idle: assert property (p_idle) else $error("strobe while idle");
endmodule : anvm_chk
bind anvm_host anvm_chk #(.STARTUP_CLKS(STARTUP_CLKS)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
   .i_brownout(i_brownout), .o_ready(o_ready), .o_cs_n(o_cs_n), .o_commit_n(o_commit_n),
   .o_out_on_n(o_out_on_n), .o_mem_addr(o_mem_addr), .o_lo_io_oe(o_lo_io_oe), .o_hi_io_oe(o_hi_io_oe));

/* File: test/anvm_host_tb.sv */
`timescale 1ns/1ps
// Host traffic against the memory model; reads are scored against a shadow copy.
module anvm_host_tb;
   localparam int SU = 20;
   logic clk = 0, rst = 1, bo = 0, req = 0, we = 0;
   logic [16:0] ad = '0;
   logic [1:0] be = '0;
   logic [15:0] wd = '0;
   logic ready, done, cs, cm, oo, ll, hl, loe, hoe, mlo, mhi;
   logic [15:0] rd, q, sh [int];
   logic [16:0] ma, al [8];
   logic [7:0] dlo, dhi, lo_w, hi_w, lo_p = '0, hi_p = '0;
   logic [32:0] e, exq [$];
   int miscompares = 0, total_checks = 0, n;
   initial forever #20 clk = ~clk;
   // Undriven lanes wander every cycle so a stale value never passes.
   always_comb lo_w = loe ? dlo : mlo ? q[7:0] : ~lo_p;
   always_comb hi_w = hoe ? dhi : mhi ? q[15:8] : ~hi_p;
   always @(posedge clk) {hi_p, lo_p} <= {hi_w, lo_w};
   anvm_host #(.STARTUP_CLKS(SU)) dut (.i_clk(clk), .i_rst(rst), .i_brownout(bo), .i_req(req), .i_we(we),
      .i_addr(ad), .i_be(be), .i_wdata(wd), .o_ready(ready), .o_done(done), .o_rdata(rd), .o_mem_addr(ma),
      .o_cs_n(cs), .o_commit_n(cm), .o_out_on_n(oo), .o_lo_lane_n(ll), .o_hi_lane_n(hl), .i_lo_io(lo_w),
      .i_hi_io(hi_w), .o_lo_io(dlo), .o_hi_io(dhi), .o_lo_io_oe(loe), .o_hi_io_oe(hoe));
   anvm_mem mem (.i_addr(ma), .i_cs_n(cs), .i_commit_n(cm), .i_out_on_n(oo), .i_lo_lane_n(ll),
      .i_hi_lane_n(hl), .i_inhibit(bo), .i_wd({hi_w, lo_w}), .o_q(q), .o_lo_oe(mlo), .o_hi_oe(mhi));
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   task cmp(string nm, logic [15:0] x, logic [15:0] g);
      total_checks++;
      if (x !== g)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
   endtask : cmp
   task wait_rdy;
      n = 0;
      while (ready !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
   endtask : wait_rdy
   // One access; the shadow copy keeps only the selected bytes.
   task acc(logic w, logic [16:0] a, logic [1:0] b, logic [15:0] d);
      logic [15:0] m;
      m = {{8{b[1]}}, {8{b[0]}}};
      wait_rdy();
      cmp("ready", 16'h1, 16'(ready));
      if (w) sh[a] = (d & m) | (sh.exists(a) ? sh[a] & ~m : 16'h0000);
      exq.push_back({w, m, sh[a] & m});
      {req, we, ad, be, wd} = {1'b1, w, a, b, d};
      @(negedge clk);
      req = 0;
   endtask : acc
   // Each finished access takes the oldest note; a pulse with none noted is a fault.
   always @(negedge clk)
      if (done === 1'b1)
      begin
         if (exq.size() == 0) cmp("spurious", 16'h0, 16'h1);
         else
         begin
            e = exq.pop_front();
            if (!e[32]) cmp("rdata", e[15:0], rd & e[31:16]);
         end
      end
   initial
   begin
      #400000;
      miscompares++;
      report_and_stop();
   end
   initial
   begin
      void'($urandom(29));
      repeat (20) @(negedge clk);
      rst = 0;
      wait_rdy();
      cmp("boot", 16'h1, 16'(n >= SU));
      $display("boot test done");
      for (int i = 0; i < 8; i++) al[i] = (i < 2) ? {17{i[0]}} : 17'($urandom);
      for (int i = 0; i < 8; i++) acc(1, al[i], 2'h3, 16'($urandom));
      for (int i = 1; i < 4; i++) acc(1, al[1], 2'(i), 16'($urandom));
      for (int i = 0; i < 4; i++) acc(0, al[1], 2'(i), 16'h0000);
      repeat (40) acc(1'($urandom), al[$urandom_range(7)], 2'($urandom), 16'($urandom));
      $display("traffic test done");
      wait_rdy();
      bo = 1;
      repeat (4) @(negedge clk);
      cmp("brown ready", 16'h0, 16'(ready));
      {req, we, ad, be, wd} = {1'b1, 1'b1, al[0], 2'h3, ~sh[al[0]]};
      repeat (4) @(negedge clk);
      {req, bo} = 2'b00;
      wait_rdy();
      cmp("rewait", 16'h1, 16'(n >= SU));
      acc(0, al[0], 2'h3, 16'h0000);
      wait_rdy();
      $display("brownout test done");
      report_and_stop();
   end
endmodule : anvm_host_tb

/* File: test/anvm_mem.sv */
`timescale 1ns/1ps
// Word memory model: read data arrives only at the worst access time.
module anvm_mem #(
   parameter int DLY = 35
)(
   input wire logic [16:0] i_addr,
   input wire logic i_cs_n,
   input wire logic i_commit_n,
   input wire logic i_out_on_n,
   input wire logic i_lo_lane_n,
   input wire logic i_hi_lane_n,
   input wire logic i_inhibit,
   input wire logic [15:0] i_wd,
   output logic [15:0] o_q,
   output logic o_lo_oe,
   output logic o_hi_oe
);
   logic [15:0] mem [0:131071];
   logic [15:0] wd;
   logic [16:0] wa;
   logic [1:0] wl;
   logic wv = 1'b0;
   int wcnt = 0;
   // Lanes drive only in a selected read and let go at once.
   assign o_lo_oe = !i_cs_n && !i_out_on_n && i_commit_n && !i_lo_lane_n;
   assign o_hi_oe = !i_cs_n && !i_out_on_n && i_commit_n && !i_hi_lane_n;
   // Old data lingers until the delay runs out.
   always @(i_addr or wcnt) o_q <= #(DLY) mem[i_addr];
   // Track the overlap; the write commits when either strobe ends it.
   always @*
      if (!i_cs_n && !i_commit_n)
      begin
         wa = i_addr;
         wd = i_wd;
         wl = {i_hi_lane_n, i_lo_lane_n};
         wv = 1'b1;
      end
   always @(posedge i_cs_n or posedge i_commit_n)
   begin
      if (wv && !i_inhibit)
      begin
         if (!wl[0]) mem[wa][7:0] = wd[7:0];
         if (!wl[1]) mem[wa][15:8] = wd[15:8];
         wcnt++;
      end
      wv = 1'b0;
   end
endmodule : anvm_mem
